// ===== design/ewcs_host.sv
// Purpose: writes a byte and waits for the device to finish programming
// Assumes: register window page given by i_win_page, inputs synchronous
// Notes:   completion by toggle read, flag polling or interrupt line
`timescale 1ns/1ps
module ewcs_host #(
    parameter int unsigned TMO_CYC = ewcs_pkg::WC_CYC
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // user request
    input  wire logic       i_req,
    input  wire logic       i_write,
    input  wire logic [1:0] i_mode,
    input  wire logic [12:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [5:0] i_win_page,
    // user answer
    output logic            o_ready,
    output logic            o_done,
    output logic            o_err,
    output logic [7:0]      o_rdata,
    // device pins
    output logic            o_ale,
    output logic            o_ce_n,
    output logic            o_wr_n,
    output logic            o_rd_n,
    output logic [7:0]      o_addr_hi,
    output logic [7:0]      o_ad,
    output logic            o_ad_oe_n,
    input  wire logic [7:0] i_ad,
    input  wire logic       i_irq_n
);
    ewcs_cyc_if cyc ();

    ewcs_pkg::ewcs_state_e state_reg;
    ewcs_pkg::ewcs_mode_e  mode_reg;
    logic                  issue_reg;
    logic [15:0]           addr_reg;
    logic [7:0]            wdata_reg;
    logic [5:0]            page_reg;
    logic [7:0]            isr_reg;
    logic                  prev_reg;
    logic                  have_prev_reg;
    logic                  fail_reg;
    logic [31:0]           tmo_reg;
    logic                  tmo;
    logic                  isr_st;
    logic                  overlap;
    logic                  same;

    // window covering the requested array byte hides it
    assign overlap = (i_win_page[5:3] == 3'b000) &&
                     (i_win_page[2:0] == i_addr[12:10]);
    assign tmo     = tmo_reg >= TMO_CYC;
    assign same    = cyc.rdata[ewcs_pkg::POLL_BIT] == prev_reg;
    assign isr_st  = state_reg == ewcs_pkg::S_RD_ISR  ||
                     state_reg == ewcs_pkg::S_CLR_ISR ||
                     state_reg == ewcs_pkg::S_FLG_RD  ||
                     state_reg == ewcs_pkg::S_ACK;

    // bus request fields follow the current state
    assign cyc.req   = issue_reg;
    assign cyc.write = state_reg == ewcs_pkg::S_CLR_ISR ||
                       state_reg == ewcs_pkg::S_WR_DATA ||
                       state_reg == ewcs_pkg::S_ACK;
    assign cyc.addr  = isr_st ? ewcs_pkg::isr_addr(page_reg) : addr_reg;
    assign cyc.wdata = state_reg == ewcs_pkg::S_WR_DATA ? wdata_reg :
                       state_reg == ewcs_pkg::S_CLR_ISR ?
                       ewcs_pkg::isr_wval(isr_reg, 1'b1,
                           mode_reg[1]) :
                       ewcs_pkg::isr_wval(isr_reg, 1'b0, 1'b0);

    assign o_ready = state_reg == ewcs_pkg::S_IDLE;
    assign o_done  = state_reg == ewcs_pkg::S_DONE;
    assign o_err   = o_done && fail_reg;

    ewcs_bus_cycle u_bus (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .cyc       (cyc.bus),
        .o_ale     (o_ale),
        .o_ce_n    (o_ce_n),
        .o_wr_n    (o_wr_n),
        .o_rd_n    (o_rd_n),
        .o_addr_hi (o_addr_hi),
        .o_ad      (o_ad),
        .o_ad_oe_n (o_ad_oe_n),
        .i_ad      (i_ad)
    );

    // operation sequencing
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg     <= ewcs_pkg::S_IDLE;
            mode_reg      <= ewcs_pkg::MODE_TOGGLE;
            issue_reg     <= 1'b0;
            addr_reg      <= 16'h0000;
            wdata_reg     <= 8'h00;
            page_reg      <= 6'h00;
            isr_reg       <= 8'h00;
            prev_reg      <= 1'b0;
            have_prev_reg <= 1'b0;
            fail_reg      <= 1'b0;
        end
        else
        begin
            issue_reg <= 1'b0;
            case (state_reg)
                ewcs_pkg::S_IDLE:
                    if (i_req)
                    begin
                        mode_reg  <= ewcs_pkg::ewcs_mode_e'(i_mode);
                        addr_reg  <= {3'b000, i_addr};
                        wdata_reg <= i_wdata;
                        page_reg  <= i_win_page;
                        fail_reg  <= 1'b0;
                        if (!i_write)
                        begin
                            state_reg <= ewcs_pkg::S_USR_RD;
                            issue_reg <= 1'b1;
                        end
                        else if (overlap)
                        begin
                            fail_reg  <= 1'b1;
                            state_reg <= ewcs_pkg::S_DONE;
                        end
                        else
                        begin
                            state_reg <= ewcs_pkg::S_RD_ISR;
                            issue_reg <= 1'b1;
                        end
                    end
                ewcs_pkg::S_RD_ISR:
                    if (cyc.done)
                    begin
                        isr_reg   <= cyc.rdata;
                        state_reg <= ewcs_pkg::S_CLR_ISR;
                        issue_reg <= 1'b1;
                    end
                ewcs_pkg::S_CLR_ISR:
                    if (cyc.done)
                    begin
                        state_reg <= ewcs_pkg::S_WR_DATA;
                        issue_reg <= 1'b1;
                    end
                ewcs_pkg::S_WR_DATA:
                    if (cyc.done)
                    begin
                        have_prev_reg <= 1'b0;
                        case (mode_reg)
                            ewcs_pkg::MODE_TOGGLE:
                            begin
                                state_reg <= ewcs_pkg::S_TGL_RD;
                                issue_reg <= 1'b1;
                            end
                            ewcs_pkg::MODE_FLAG:
                            begin
                                state_reg <= ewcs_pkg::S_FLG_RD;
                                issue_reg <= 1'b1;
                            end
                            default:
                                state_reg <= ewcs_pkg::S_IRQ_WAIT;
                        endcase
                    end
                ewcs_pkg::S_TGL_RD:
                    if (cyc.done)
                    begin
                        if (have_prev_reg && same)
                            state_reg <= ewcs_pkg::S_DONE;
                        else if (tmo)
                        begin
                            fail_reg  <= 1'b1;
                            state_reg <= ewcs_pkg::S_DONE;
                        end
                        else
                        begin
                            prev_reg      <= cyc.rdata[ewcs_pkg::POLL_BIT];
                            have_prev_reg <= 1'b1;
                            issue_reg     <= 1'b1;
                        end
                    end
                ewcs_pkg::S_FLG_RD:
                    if (cyc.done)
                    begin
                        isr_reg <= cyc.rdata;
                        if (cyc.rdata[ewcs_pkg::EOW_BIT])
                        begin
                            state_reg <= ewcs_pkg::S_ACK;
                            issue_reg <= 1'b1;
                        end
                        else if (tmo)
                        begin
                            fail_reg  <= 1'b1;
                            state_reg <= ewcs_pkg::S_DONE;
                        end
                        else if (mode_reg == ewcs_pkg::MODE_FLAG)
                            issue_reg <= 1'b1;
                        else
                            state_reg <= ewcs_pkg::S_IRQ_WAIT;
                    end
                ewcs_pkg::S_IRQ_WAIT:
                    if (!i_irq_n)
                    begin
                        state_reg <= ewcs_pkg::S_FLG_RD;
                        issue_reg <= 1'b1;
                    end
                    else if (tmo)
                    begin
                        fail_reg  <= 1'b1;
                        state_reg <= ewcs_pkg::S_DONE;
                    end
                ewcs_pkg::S_ACK,
                ewcs_pkg::S_USR_RD:
                    if (cyc.done)
                        state_reg <= ewcs_pkg::S_DONE;
                ewcs_pkg::S_DONE:
                    state_reg <= ewcs_pkg::S_IDLE;
                default:
                    state_reg <= ewcs_pkg::S_IDLE;
            endcase
        end
    end

    // programming timeout, started by the data write
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tmo_reg <= 32'h0000_0000;
        else if (state_reg == ewcs_pkg::S_WR_DATA)
            tmo_reg <= 32'h0000_0000;
        else if (!tmo)
            tmo_reg <= tmo_reg + 32'h0000_0001;
    end

    // read data to the user
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (cyc.done && (state_reg == ewcs_pkg::S_USR_RD ||
                              state_reg == ewcs_pkg::S_TGL_RD))
            o_rdata <= cyc.rdata;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_irq_seen;
        state_reg == ewcs_pkg::S_IRQ_WAIT && !i_irq_n;
    endsequence
    sequence s_isr_read;
        state_reg == ewcs_pkg::S_FLG_RD && cyc.req && !cyc.write;
    endsequence
    sequence s_flag_seen;
        state_reg == ewcs_pkg::S_FLG_RD && cyc.done &&
        cyc.rdata[ewcs_pkg::EOW_BIT];
    endsequence
    sequence s_ack_done;
        state_reg == ewcs_pkg::S_ACK ##[53:59] state_reg == ewcs_pkg::S_DONE;
    endsequence

    clear_first_a: assert property (
        $rose(state_reg == ewcs_pkg::S_WR_DATA) |->
        $past(state_reg) == ewcs_pkg::S_CLR_ISR && !fail_reg)
        else $error("data write not preceded by flag clear");
    flag_zeroed_a: assert property (
        cyc.req && cyc.write && isr_st |-> !cyc.wdata[ewcs_pkg::EOW_BIT])
        else $error("status write leaves done flag set");
    irq_follow_a: assert property (
        s_irq_seen |=> s_isr_read)
        else $error("interrupt not followed by status read");
    flag_ack_a: assert property (
        s_flag_seen |=> s_ack_done)
        else $error("done flag not acknowledged");
    toggle_repoll_a: assert property (
        state_reg == ewcs_pkg::S_TGL_RD && cyc.done && have_prev_reg &&
        !same && !tmo |=> cyc.req && state_reg == ewcs_pkg::S_TGL_RD)
        else $error("toggle poll stopped while bit changing");
    toggle_end_a: assert property (
        state_reg == ewcs_pkg::S_TGL_RD && cyc.done && have_prev_reg &&
        same |=> o_done && !o_err ##1 o_ready)
        else $error("toggle poll did not end on stable bit");

endmodule : ewcs_host

// ===== design/ewcs_pkg.sv
// Purpose: constants and types for the write-completion host controller
// Assumes: 200 MHz clock, byte-wide multiplexed address/data bus
// Notes:   the far side is the nonvolatile memory device
package ewcs_pkg;

    localparam int unsigned CLK_NS     = 5;
    // bus timing in ns
    localparam int unsigned T_ALE_NS   = 80;
    localparam int unsigned T_AHOLD_NS = 30;
    localparam int unsigned T_WR_NS    = 120;
    localparam int unsigned T_RD_NS    = 150;
    localparam int unsigned T_DHOLD_NS = 30;
    // longest internal write cycle in ms
    localparam int unsigned T_WC_MS    = 5;

    // least time, rounded up to whole cycles
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction : ns_to_cyc

    localparam logic [7:0]  ALE_CYC = 8'(ns_to_cyc(T_ALE_NS));
    localparam logic [7:0]  AH_CYC  = 8'(ns_to_cyc(T_AHOLD_NS));
    localparam logic [7:0]  WR_CYC  = 8'(ns_to_cyc(T_WR_NS));
    localparam logic [7:0]  RD_CYC  = 8'(ns_to_cyc(T_RD_NS));
    localparam logic [7:0]  DH_CYC  = 8'(ns_to_cyc(T_DHOLD_NS));
    localparam int unsigned WC_CYC  = T_WC_MS * 1000000 / CLK_NS;

    // memory map
    localparam int unsigned PAGE_W    = 6;
    localparam int unsigned ARRAY_W   = 13;
    localparam logic [9:0]  ISR_OFS   = 10'h004;
    localparam int unsigned EOW_BIT   = 3;
    localparam int unsigned WRITE_DONE_IRQ_ENABLE_BIT  = 2;
    localparam int unsigned POLL_BIT  = 6;

    typedef enum logic [1:0] {
        MODE_TOGGLE = 2'b00,
        MODE_FLAG   = 2'b01,
        MODE_IRQ    = 2'b10
    } ewcs_mode_e;

    typedef enum logic [2:0] {
        B_IDLE  = 3'b000,
        B_ALE   = 3'b001,
        B_AHOLD = 3'b010,
        B_STRB  = 3'b011,
        B_HOLD  = 3'b100
    } ewcs_bus_e;

    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_RD_ISR   = 4'b0001,
        S_CLR_ISR  = 4'b0010,
        S_WR_DATA  = 4'b0011,
        S_TGL_RD   = 4'b0100,
        S_FLG_RD   = 4'b0101,
        S_IRQ_WAIT = 4'b0110,
        S_ACK      = 4'b0111,
        S_USR_RD   = 4'b1000,
        S_DONE     = 4'b1001
    } ewcs_state_e;

    // register window address of the interrupt status register
    function automatic logic [15:0] isr_addr(input logic [5:0] page);
        return {page, ISR_OFS};
    endfunction : isr_addr

    // status write value: done flag zeroed, enable optionally forced
    function automatic logic [7:0] isr_wval(input logic [7:0] interrupt_status_reg,
                                            input logic       set_en,
                                            input logic       en);
        logic [7:0] v;
        v = interrupt_status_reg;
        v[EOW_BIT] = 1'b0;
        if (set_en)
        begin
            v[WRITE_DONE_IRQ_ENABLE_BIT] = en;
        end
        return v;
    endfunction : isr_wval

endpackage : ewcs_pkg

// ===== design/ewcs_cyc_if.sv
// Purpose: one bus cycle request between sequencer and pin driver
// Assumes: req is a one-cycle pulse given only while the driver is idle
// Notes:   done pulses once per cycle, rdata valid with it
`timescale 1ns/1ps
interface ewcs_cyc_if;
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;

    modport ctrl (output req, write, addr, wdata, input done, rdata);
    modport bus  (input req, write, addr, wdata, output done, rdata);
endinterface : ewcs_cyc_if

// ===== design/ewcs_bus_cycle.sv
// Purpose: drives one multiplexed address/data bus cycle
// Assumes: i_ad synchronous to i_clk
// Notes:   pins are registered one cycle behind the state
`timescale 1ns/1ps
module ewcs_bus_cycle (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // request side
    ewcs_cyc_if.bus         cyc,
    // device pins
    output logic            o_ale,
    output logic            o_ce_n,
    output logic            o_wr_n,
    output logic            o_rd_n,
    output logic [7:0]      o_addr_hi,
    output logic [7:0]      o_ad,
    output logic            o_ad_oe_n,
    input  wire logic [7:0] i_ad
);
    ewcs_pkg::ewcs_bus_e state_reg;
    logic [7:0]          cnt_reg;
    logic                wr_reg;
    logic [15:0]         addr_reg;
    logic [7:0]          wdata_reg;
    logic [7:0]          rdata_reg;
    logic                done_reg;
    logic                last;

    assign last      = (cnt_reg == 8'h00);
    assign cyc.done  = done_reg;
    assign cyc.rdata = rdata_reg;

    // phase sequencing
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ewcs_pkg::B_IDLE;
            cnt_reg   <= 8'h00;
            wr_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                ewcs_pkg::B_IDLE:
                    if (cyc.req)
                    begin
                        wr_reg    <= cyc.write;
                        addr_reg  <= cyc.addr;
                        wdata_reg <= cyc.wdata;
                        cnt_reg   <= ewcs_pkg::ALE_CYC - 8'h01;
                        state_reg <= ewcs_pkg::B_ALE;
                    end
                ewcs_pkg::B_ALE:
                    if (last)
                    begin
                        cnt_reg   <= ewcs_pkg::AH_CYC - 8'h01;
                        state_reg <= ewcs_pkg::B_AHOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                ewcs_pkg::B_AHOLD:
                    if (last)
                    begin
                        cnt_reg   <= wr_reg ? ewcs_pkg::WR_CYC - 8'h01
                                            : ewcs_pkg::RD_CYC - 8'h01;
                        state_reg <= ewcs_pkg::B_STRB;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                ewcs_pkg::B_STRB:
                    if (last)
                    begin
                        cnt_reg   <= ewcs_pkg::DH_CYC - 8'h01;
                        state_reg <= ewcs_pkg::B_HOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                ewcs_pkg::B_HOLD:
                    if (last)
                        state_reg <= ewcs_pkg::B_IDLE;
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                default:
                    state_reg <= ewcs_pkg::B_IDLE;
            endcase
        end
    end

    // pin drive
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_ale     <= 1'b0;
            o_ce_n    <= 1'b1;
            o_wr_n    <= 1'b1;
            o_rd_n    <= 1'b1;
            o_addr_hi <= 8'h00;
            o_ad      <= 8'h00;
            o_ad_oe_n <= 1'b1;
        end
        else
        begin
            o_ale     <= state_reg == ewcs_pkg::B_ALE;
            o_ce_n    <= state_reg == ewcs_pkg::B_IDLE;
            o_wr_n    <= !(state_reg == ewcs_pkg::B_STRB && wr_reg);
            o_rd_n    <= !(state_reg == ewcs_pkg::B_STRB && !wr_reg);
            o_addr_hi <= addr_reg[15:8];
            if (state_reg == ewcs_pkg::B_ALE ||
                state_reg == ewcs_pkg::B_AHOLD)
            begin
                o_ad      <= addr_reg[7:0];
                o_ad_oe_n <= 1'b0;
            end
            else
            begin
                o_ad      <= wdata_reg;
                o_ad_oe_n <= !(wr_reg && (state_reg == ewcs_pkg::B_STRB ||
                                          state_reg == ewcs_pkg::B_HOLD));
            end
        end
    end

    // read capture and completion
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_reg <= 8'h00;
            done_reg  <= 1'b0;
        end
        else
        begin
            if (state_reg == ewcs_pkg::B_STRB && last && !wr_reg)
                rdata_reg <= i_ad;
            done_reg <= state_reg == ewcs_pkg::B_HOLD && last;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    wr_pulse_width_a: assert property (
        $fell(o_wr_n) |-> ##23 !o_wr_n ##1 o_wr_n)
        else $error("write strobe width wrong");
    cycle_length_a: assert property (
        cyc.req |-> ##[53:59] cyc.done)
        else $error("bus cycle length wrong");

endmodule : ewcs_bus_cycle

// ===== sim/ewcs_dev_model.sv
// Purpose: behavioural nonvolatile memory device on the muxed bus
// Assumes: pins sampled on i_clk, i_wc cycles of programming
// Notes:   irq line open drain, pulled up by the bench
`timescale 1ns/1ps
module ewcs_dev_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // setup
    input  wire logic [5:0]  i_win_page,
    input  wire logic [15:0] i_wc,
    // host pins
    input  wire logic        i_ale,
    input  wire logic        i_ce_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_rd_n,
    input  wire logic [7:0]  i_addr_hi,
    input  wire logic [7:0]  i_ad,
    output logic      [7:0]  o_ad,
    output tri               o_irq_n
);
    logic [7:0]  mem_reg [0:8191];
    logic [15:0] adr_reg;
    logic [7:0]  isr_reg;
    logic [15:0] busy_reg;
    logic        plane_reg;
    logic        tgl_reg;
    logic        rd_prev_reg;
    logic        wr_prev_reg;
    logic [7:0]  last_reg;
    logic        is_win;
    logic        is_isr;
    logic        is_arr;
    logic        locked;
    logic [7:0]  rd_val;

    assign is_win = adr_reg[15:10] == i_win_page;
    assign is_isr = is_win && adr_reg[9:0] == ewcs_pkg::ISR_OFS;
    assign is_arr = !is_win && adr_reg[15:13] == 3'h0;
    // only the plane under programming is shut
    assign locked = busy_reg != 16'h0 &&
                    adr_reg[12] == plane_reg;
    always_comb
    begin
        rd_val = 8'hff;
        if (is_isr)
            rd_val = isr_reg;
        else if (is_arr)
            rd_val = mem_reg[adr_reg[12:0]];
        if (is_arr && locked)
            rd_val[6] = tgl_reg;
    end
    // released lines show a changing pattern
    assign o_ad = (!i_ce_n && !i_rd_n) ? rd_val : ~last_reg;
    assign o_irq_n = (isr_reg[ewcs_pkg::EOW_BIT] &&
                      isr_reg[ewcs_pkg::WRITE_DONE_IRQ_ENABLE_BIT]) ? 1'b0 : 1'bz;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            adr_reg     <= 16'h0000;
            isr_reg     <= 8'h00;
            busy_reg    <= 16'h0000;
            plane_reg   <= 1'b0;
            tgl_reg     <= 1'b0;
            rd_prev_reg <= 1'b1;
            wr_prev_reg <= 1'b1;
            last_reg    <= 8'h00;
        end
        else
        begin
            rd_prev_reg <= i_rd_n;
            wr_prev_reg <= i_wr_n;
            last_reg    <= o_ad;
            if (i_ale)
                adr_reg <= {i_addr_hi, i_ad};
            if (!rd_prev_reg && i_rd_n && is_arr && locked)
                tgl_reg <= !tgl_reg;
            if (busy_reg != 16'h0000)
                busy_reg <= busy_reg - 16'h0001;
            if (busy_reg == 16'h0001)
                isr_reg[ewcs_pkg::EOW_BIT] <= 1'b1;
            if (!wr_prev_reg && i_wr_n && !i_ce_n)
            begin
                if (is_isr)
                begin
                    isr_reg <= i_ad;
                    isr_reg[ewcs_pkg::EOW_BIT] <= isr_reg[ewcs_pkg::EOW_BIT]
                        & i_ad[ewcs_pkg::EOW_BIT];
                end
                else if (is_arr && !locked)
                begin
                    mem_reg[adr_reg[12:0]] <= i_ad;
                    busy_reg  <= i_wc;
                    plane_reg <= adr_reg[12];
                end
            end
        end
    end
endmodule : ewcs_dev_model

// ===== sim/ewcs_host_test.sv
// Purpose: self-checking bench for the write-completion host
// Assumes: device model on the far side, short timeout
// Notes:   inputs driven 1 ns after the rising edge
`timescale 1ns/1ps
module ewcs_host_test;
    logic i_clk, i_rst_n, i_req, i_write, o_ready, o_done, o_err;
    logic [1:0] i_mode;
    logic [12:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_ad, i_ad, o_addr_hi;
    logic [5:0] i_win_page;
    logic [15:0] wc;
    logic o_ale, o_ce_n, o_wr_n, o_rd_n, o_ad_oe_n, e;
    tri1 irq_n;
    int failures, check_count;

    ewcs_host #(.TMO_CYC(2000)) ewcs_host_inst (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_req(i_req), .i_write(i_write),
        .i_mode(i_mode), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_win_page(i_win_page), .o_ready(o_ready), .o_done(o_done),
        .o_err(o_err), .o_rdata(o_rdata), .o_ale(o_ale), .o_ce_n(o_ce_n),
        .o_wr_n(o_wr_n), .o_rd_n(o_rd_n), .o_addr_hi(o_addr_hi),
        .o_ad(o_ad), .o_ad_oe_n(o_ad_oe_n), .i_ad(i_ad), .i_irq_n(irq_n));
    ewcs_dev_model ewcs_dev_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_win_page(i_win_page), .i_wc(wc), .i_ale(o_ale),
        .i_ce_n(o_ce_n), .i_wr_n(o_wr_n), .i_rd_n(o_rd_n),
        .i_addr_hi(o_addr_hi), .i_ad(o_ad), .o_ad(i_ad), .o_irq_n(irq_n));

    always #2.5 i_clk = ~i_clk;

    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one user request, bounded wait for completion
    task automatic op(input logic wr, input logic [1:0] md,
        input logic [12:0] a, input logic [7:0] d, input logic [5:0] pg);
        int n;
        i_write = wr;
        i_mode = md;
        i_addr = a;
        i_wdata = d;
        i_win_page = pg;
        i_req = 1'b1;
        @(posedge i_clk);
        #1;
        i_req = 1'b0;
        n = 0;
        while (n < 20000 && o_done !== 1'b1)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 20000)
        begin
            failures++;
            summarize();
        end
        e = o_err;
        @(posedge i_clk);
        #1;
    endtask : op

    task automatic t_toggle;
        op(1'b1, 2'b00, 13'h0123, 8'ha5, 6'h3f);
        check({7'h00, e}, 8'h00);
        check(o_rdata, 8'ha5);
        op(1'b0, 2'b00, 13'h0123, 8'h00, 6'h3f);
        check(o_rdata, 8'ha5);
        $display("toggle poll test done");
    endtask : t_toggle

    task automatic t_flag;
        op(1'b1, 2'b01, 13'h1456, 8'h3c, 6'h20);
        check({7'h00, e}, 8'h00);
        op(1'b0, 2'b01, 13'h1456, 8'h00, 6'h20);
        check(o_rdata, 8'h3c);
        $display("flag poll test done");
    endtask : t_flag

    task automatic t_irq;
        op(1'b1, 2'b10, 13'h0004, 8'h5a, 6'h3f);
        check({7'h00, e}, 8'h00);
        op(1'b1, 2'b11, 13'h1004, 8'h69, 6'h3f);
        check({7'h00, e}, 8'h00);
        check({7'h00, irq_n}, 8'h01);
        op(1'b0, 2'b10, 13'h0004, 8'h00, 6'h00);
        check(o_rdata, 8'h04);
        op(1'b0, 2'b10, 13'h0004, 8'h00, 6'h3f);
        check(o_rdata, 8'h5a);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_refuse;
        op(1'b1, 2'b01, 13'h0812, 8'h11, 6'h02);
        check({7'h00, e}, 8'h01);
        check({7'h00, o_ce_n}, 8'h01);
        $display("overlap refuse test done");
    endtask : t_refuse

    task automatic t_timeout;
        wc = 16'd5000;
        op(1'b1, 2'b01, 13'h0200, 8'h77, 6'h3f);
        check({7'h00, e}, 8'h01);
        $display("timeout test done");
    endtask : t_timeout

    initial
    begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_req = 1'b0;
        i_write = 1'b0;
        i_mode = 2'b00;
        i_addr = 13'h0000;
        i_wdata = 8'h00;
        i_win_page = 6'h3f;
        wc = 16'd300;
        failures = 0;
        check_count = 0;
        repeat (16) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        check({o_ready, o_ce_n, o_ad_oe_n, o_wr_n, o_rd_n, o_ale, o_done,
               o_err}, 8'hf8);
        t_toggle();
        t_flag();
        t_irq();
        t_refuse();
        t_timeout();
        summarize();
    end
endmodule : ewcs_host_test
